// File: hw/pdh_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// two-stage synchroniser for asynchronous pad levels
// ****************************************************************
module pdh_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // first stage feeds only the second
   always_comb begin
      meta_d = clk_en ? async_i : meta_q;
      sync_d = clk_en ? meta_q : sync_q;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;

endmodule

// File: hw/pdh_top.sv
`timescale 1ns/1ps
// ****************************************************************
// pin power-down hold
// ****************************************************************

// Overview of operation
// [R1] power-down is optional; only when enabled does the pin request sleep
// [R2] hold while the sleep pin is high, leave when it falls low
// [R3] outputs, registers and logic state are frozen during hold
// [R4] a pad tri-stated at hold entry stays tri-stated until exit
// [R5] all inputs except the sleep pin are ignored during hold
// [R6] pad keepers stay active and retain each pad's last level
// [R7] the enable comes only from configuration, fixed after reset
// [R8] with the feature enabled, the sleep pin's array input is unavailable
// [R9] partner keeps inputs, enables, clocks valid 15 ns before sleep rises
// [R10] partner may change inputs only 25 ns after sleep rises
// [R11] partner allows up to 1 us after sleep falls before inputs count
// [R12] outputs are valid again within 1 us after sleep falls
module pdh_top (
   input  wire logic                      clk,
   input  wire logic                      rst_b,
   input  wire logic                      clk_en,
   input  wire logic                      cfg_pd_enable,
   input  wire logic                      sleep_request_pin,
   input  wire logic [pdh_pkg::PIN_W-1:0] pad_i,
   input  wire logic [pdh_pkg::PIN_W-1:0] core_out,
   input  wire logic [pdh_pkg::PIN_W-1:0] core_oe,
   output logic      [pdh_pkg::PIN_W-1:0] pad_o,
   output logic      [pdh_pkg::PIN_W-1:0] pad_oe,
   output logic      [pdh_pkg::PIN_W-1:0] core_in,
   output logic                           sleep_array_in,
   output logic                           hold_active
);

   // ****************************************************************
   // pad synchronisers
   // ****************************************************************
   logic                      sleep_s;
   logic [pdh_pkg::PIN_W-1:0] pad_s;

   pdh_sync #(
      .WIDTH (pdh_pkg::PIN_W + 1)
   ) u_sync (
      .clk     (clk),
      .rst_b   (rst_b),
      .clk_en  (clk_en),
      .async_i ({sleep_request_pin, pad_i}),
      .sync_o  ({sleep_s, pad_s})
   );

   // ****************************************************************
   // configuration capture
   // ****************************************************************
   logic cfg_en_q;
   logic cfg_en_d;
   logic cfg_done_q;
   logic cfg_done_d;

   // [R7] latched once after reset
   // a strap cannot be taken under reset, so the first enabled edge loads it
   always_comb begin
      cfg_en_d   = cfg_en_q;
      cfg_done_d = cfg_done_q;
      if (clk_en && !cfg_done_q) begin
         cfg_en_d   = cfg_pd_enable;
         cfg_done_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_en_q   <= 1'b0;
         cfg_done_q <= 1'b0;
      end else begin
         cfg_en_q   <= cfg_en_d;
         cfg_done_q <= cfg_done_d;
      end
   end

   // ****************************************************************
   // hold sequencing
   // ****************************************************************
   pdh_pkg::pdh_state_e              state_q;
   pdh_pkg::pdh_state_e              state_d;
   logic [pdh_pkg::WAKE_W-1:0]       wake_q;
   logic [pdh_pkg::WAKE_W-1:0]       wake_d;
   logic                             sleep_req;

   // [R1] sleep request honoured only when the option is configured
   assign sleep_req = cfg_en_q & cfg_done_q & sleep_s;

   // wake settles inputs for the partner's recovery time;
   // a new sleep request during wake goes straight back to hold
   always_comb begin
      state_d = state_q;
      wake_d  = wake_q;
      if (clk_en) begin
         unique case (state_q)
            // [R2] enter hold
            pdh_pkg::PDH_RUN: begin
               if (sleep_req) begin
                  state_d = pdh_pkg::PDH_HOLD;
               end
            end
            // [R2] leave hold on falling request
            pdh_pkg::PDH_HOLD: begin
               if (!sleep_req) begin
                  state_d = pdh_pkg::PDH_WAKE;
                  wake_d  = pdh_pkg::WAKE_W'(pdh_pkg::WAKE_CYC - 1);
               end
            end
            // [R11] input recovery window
            pdh_pkg::PDH_WAKE: begin
               if (sleep_req) begin
                  state_d = pdh_pkg::PDH_HOLD;
               end else if (wake_q == pdh_pkg::WAKE_RST) begin
                  state_d = pdh_pkg::PDH_RUN;
               end else begin
                  wake_d = wake_q - 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= pdh_pkg::PDH_RUN;
         wake_q  <= pdh_pkg::WAKE_RST;
      end else begin
         state_q <= state_d;
         wake_q  <= wake_d;
      end
   end

   // ****************************************************************
   // pad keepers, input gating and output registers
   // ****************************************************************
   logic [pdh_pkg::PIN_W-1:0] keep_q;
   logic [pdh_pkg::PIN_W-1:0] keep_d;
   logic [pdh_pkg::PIN_W-1:0] out_q;
   logic [pdh_pkg::PIN_W-1:0] out_d;
   logic [pdh_pkg::PIN_W-1:0] oe_q;
   logic [pdh_pkg::PIN_W-1:0] oe_d;
   logic                      arr_q;
   logic                      arr_d;
   logic                      hold_q;
   logic                      hold_d;
   logic                      frozen;
   logic                      take_in;

   // frozen from the edge that sees the request, so nothing moves after it
   assign frozen  = sleep_req || (state_q == pdh_pkg::PDH_HOLD);
   // inputs are trusted again only after the recovery window
   assign take_in = !frozen && (state_q == pdh_pkg::PDH_RUN);

   always_comb begin
      keep_d = keep_q;
      out_d  = out_q;
      oe_d   = oe_q;
      arr_d  = arr_q;
      hold_d = hold_q;
      if (clk_en) begin
         hold_d = frozen;
         // [R6] keepers retain the last pad level; [R5] no update in hold
         if (take_in) begin
            keep_d = pad_s;
         end
         // [R3] output values frozen; [R4] enables frozen too
         // [R12] outputs never go invalid, core drives resume at once
         if (!frozen) begin
            out_d = core_out;
            oe_d  = core_oe;
         end
         // [R8] pin array input reads zero when it serves as sleep request
         arr_d = cfg_en_q ? 1'b0 : sleep_s;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         keep_q <= pdh_pkg::PIN_RST;
         out_q  <= pdh_pkg::PIN_RST;
         oe_q   <= pdh_pkg::PIN_RST;
         arr_q  <= 1'b0;
         hold_q <= 1'b0;
      end else begin
         keep_q <= keep_d;
         out_q  <= out_d;
         oe_q   <= oe_d;
         arr_q  <= arr_d;
         hold_q <= hold_d;
      end
   end

   // outputs straight from flip-flops
   assign pad_o          = out_q;
   assign pad_oe         = oe_q;
   assign core_in        = keep_q;
   assign sleep_array_in = arr_q;
   assign hold_active    = hold_q;

endmodule

// File: pkg/pdh_pkg.sv
// ****************************************************************
// constants for the pin power-down hold block
// ****************************************************************
package pdh_pkg;

   // pad group width
   localparam int unsigned PIN_W = 8;

   // clock period
   localparam int unsigned CLK_PERIOD_NS = 100;

   // longest time from sleep release to valid inputs and outputs
   localparam int unsigned WAKE_TIME_NS = 1000;
   // a longest time rounds down, never below one cycle
   localparam int unsigned WAKE_CYC_RAW = WAKE_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned WAKE_CYC     = (WAKE_CYC_RAW < 1) ? 1 : WAKE_CYC_RAW;
   localparam int unsigned WAKE_W       = $clog2(WAKE_CYC + 1);

   // partner timing around the sleep edge, kept for reference by the bench
   localparam int unsigned ENTRY_SETUP_NS = 15;
   localparam int unsigned ENTRY_DONE_NS  = 25;

   // reset values
   localparam logic [PIN_W-1:0]  PIN_RST  = 8'h00;
   localparam logic [WAKE_W-1:0] WAKE_RST = '0;

   typedef enum logic [1:0] {
      PDH_RUN,
      PDH_HOLD,
      PDH_WAKE
   } pdh_state_e;

endpackage

// File: verification/pdh_partner.sv
`timescale 1ns/1ps
// ****************************************************************
// system logic driving the sleep and pad pins
// ****************************************************************
module pdh_partner (
   input  wire logic                      sleep_cmd,
   input  wire logic [pdh_pkg::PIN_W-1:0] pad_cmd,
   output logic                           sleep_request_pin,
   output logic      [pdh_pkg::PIN_W-1:0] pad_i
);
   logic guard = 1'b0;

   // pins start low so nothing floats before the first request
   initial begin
      sleep_request_pin = 1'b0;
      pad_i = '0;
   end

   // pads follow requests only outside the guard window
   always @(pad_cmd or guard) begin
      if (!guard) begin
         pad_i = pad_cmd;
      end
   end

   always @(sleep_cmd) begin
      guard = 1'b1;
      if (sleep_cmd) begin
         #(pdh_pkg::ENTRY_SETUP_NS) sleep_request_pin = 1'b1;
         #(pdh_pkg::ENTRY_DONE_NS) guard = 1'b0;
      end else begin
         sleep_request_pin = 1'b0;
         #(pdh_pkg::WAKE_TIME_NS) guard = 1'b0;
      end
   end
endmodule

// File: verification/pdh_top_props.sv
`timescale 1ns/1ps
// ****************************************************************
// timing checks at the pins of the power-down hold block
// ****************************************************************
module pdh_top_props (
   input wire logic                      clk,
   input wire logic                      rst_b,
   input wire logic                      cfg_pd_enable,
   input wire logic                      sleep_request_pin,
   input wire logic [pdh_pkg::PIN_W-1:0] core_out,
   input wire logic [pdh_pkg::PIN_W-1:0] pad_o,
   input wire logic [pdh_pkg::PIN_W-1:0] pad_oe,
   input wire logic [pdh_pkg::PIN_W-1:0] core_in,
   input wire logic                      sleep_array_in,
   input wire logic                      hold_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   sleep_enter_a: assert property ((cfg_pd_enable && sleep_request_pin) [*3] |=> hold_active)
      else $error("hold not entered three edges after sleep pin");
   // exit after sync, one more edge to move from hold into wake
   sleep_leave_a: assert property (!sleep_request_pin [*4] |=> !hold_active)
      else $error("hold not left after sleep pin fell");
   feature_off_a: assert property (!cfg_pd_enable |-> !hold_active)
      else $error("hold entered with feature disabled");
   array_block_a: assert property (cfg_pd_enable |-> !sleep_array_in)
      else $error("sleep pin reached array while feature enabled");
   array_path_a: assert property ((!cfg_pd_enable && sleep_request_pin) [*3] |=> sleep_array_in)
      else $error("sleep pin missing from array with feature off");
   out_frozen_a: assert property (hold_active ##1 hold_active |-> $stable(pad_o))
      else $error("pad output moved during hold");
   tristate_kept_a: assert property (hold_active ##1 hold_active |-> $stable(pad_oe))
      else $error("pad enable moved during hold");
   keeper_frozen_a: assert property (hold_active ##1 hold_active |-> $stable(core_in))
      else $error("pad view moved during hold");
   wake_output_a: assert property ($fell(hold_active) |-> pad_o == $past(core_out))
      else $error("pad output not following user logic after hold");

   // main scenarios
   cover property (hold_active ##1 !hold_active);
   cover property (!cfg_pd_enable && sleep_array_in);
   cover property (hold_active && pad_oe != '0);
endmodule

bind pdh_top pdh_top_props pdh_top_props_i (.clk, .rst_b, .cfg_pd_enable, .sleep_request_pin,
   .core_out, .pad_o, .pad_oe, .core_in, .sleep_array_in, .hold_active);

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam int unsigned W = pdh_pkg::PIN_W;
   logic         clk = 1'b0;
   logic         rst_b = 1'b0;
   logic         cfg = 1'b1;
   logic         en = 1'b1;
   logic         sleep_cmd = 1'b0;
   logic [W-1:0] pad_cmd = '0;
   logic [W-1:0] core_out = '0;
   logic [W-1:0] core_oe = '0;
   logic [W-1:0] v;
   logic [W-1:0] p;
   wire logic    sleep_pin;
   wire logic [W-1:0] pad_i;
   logic [W-1:0] pad_o, pad_oe, core_in;
   logic         sleep_array_in, hold_active;
   logic [W-1:0] exp_q[$];
   int           mismatches = 0;
   int           check_count = 0;
   int           cyc = 0;

   always #50 clk = ~clk;

   pdh_partner pdh_partner_i (.sleep_cmd(sleep_cmd), .pad_cmd(pad_cmd), .sleep_request_pin(sleep_pin),
      .pad_i(pad_i));
   pdh_top pdh_top_i (.clk(clk), .rst_b(rst_b), .clk_en(en), .cfg_pd_enable(cfg),
      .sleep_request_pin(sleep_pin), .pad_i(pad_i), .core_out(core_out), .core_oe(core_oe),
      .pad_o(pad_o), .pad_oe(pad_oe), .core_in(core_in), .sleep_array_in(sleep_array_in),
      .hold_active(hold_active));

   task automatic check(string name, logic [W-1:0] seen, logic [W-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // drive one cycle of user traffic and note the pad value due one edge later
   task automatic step(logic [W-1:0] d, logic [W-1:0] e);
      @(negedge clk);
      core_out = d;
      core_oe = ~d;
      exp_q.push_back(e);
   endtask

   task automatic run(int n);
      repeat (n) begin
         v = W'($urandom);
         step(v, v);
      end
   endtask

   // keep outputs steady until hold reaches the wanted level, bounded
   task automatic wait_hold(logic lvl);
      int n;
      n = 0;
      while (hold_active !== lvl && n < 12) begin
         step(v, v);
         n++;
      end
      if (n == 12) check("hold_active", W'(hold_active), W'(lvl));
   endtask

   // compare pads against the oldest note once each edge has landed
   always @(posedge clk) begin
      #1;
      if (exp_q.size() > 0) begin
         check("pad_o", pad_o, exp_q[0]);
         check("pad_oe", pad_oe, ~exp_q.pop_front());
      end
   end

   // cut a hang short well beyond the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         mismatches++;
         conclude();
      end
   end

   initial begin
      void'($urandom(88491));
      repeat (4) @(posedge clk);
      @(negedge clk) rst_b = 1'b1;
      run(6);
      p = W'($urandom);
      pad_cmd = p;
      run(4);
      check("core_in", core_in, p);
      $display("test run done");
      repeat (3) step(v, v);
      // clock enable low: output registers must ignore new user values
      en = 1'b0;
      repeat (3) step(W'($urandom), v);
      step(v, v);
      en = 1'b1;
      sleep_cmd = 1'b1;
      wait_hold(1'b1);
      check("sleep_array_in", W'(sleep_array_in), '0);
      repeat (5) begin
         step(W'($urandom), v);
         pad_cmd = W'($urandom);
      end
      check("core_in", core_in, p);
      sleep_cmd = 1'b0;
      wait_hold(1'b0);
      check("core_in", core_in, p);
      run(14);
      check("core_in", core_in, pad_cmd);
      $display("test hold done");
      repeat (2) @(negedge clk);
      rst_b = 1'b0;
      cfg = 1'b0;
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      sleep_cmd = 1'b1;
      run(6);
      check("hold_active", W'(hold_active), '0);
      check("sleep_array_in", W'(sleep_array_in), W'(1'b1));
      sleep_cmd = 1'b0;
      run(2);
      // let the last noted pad value be compared before the verdict
      @(negedge clk);
      $display("test disabled done");
      conclude();
   end
endmodule
